// ### desat_channel.sv
// one channel: blanking, filter, soft shutdown and fault blocking
module desat_channel
   import desat_pkg::*;
#(
   parameter int FAULT_HOLD_CYC = FAULT_HOLD_CYC_DEF
)
(
   input wire logic clock_i, // core clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic cmd_on_i, // switch command, high means on
   input wire logic over_threshold_i, // sense above detect_threshold_ref
   input wire logic [CNT_W-1:0] response_cyc_i, // configured response time in cycles
   output logic gate_turn_on_out_o, // turn-on stage enable
   output logic gate_turn_off_out_o, // turn-off stage enable
   output logic [SSD_STEP_W-1:0] gate_level_o, // gate drive level, ramps on soft shutdown
   output logic sense_clamp_o, // pull collector_sense to negative_rail
   output logic fault_status_out_oe_o, // open-drain pull-down enable
   output logic fault_pulse_o // one-cycle pulse on confirmed fault
);
   chan_state_t state_reg;
   logic [CNT_W-1:0] time_reg; // cycles since turn-on
   logic [CNT_W-1:0] filt_reg; // cycles continuously over threshold
   logic [CNT_W-1:0] block_reg; // blocking and fault hold counter
   logic [CNT_W-1:0] ssd_reg; // soft shutdown step counter
   logic [CNT_W-1:0] blank_end;
   logic confirm;

   // a longer configured response stretches the blanking; the floor is min latency
   function automatic logic [CNT_W-1:0] blank_len(input logic [CNT_W-1:0] resp);
      logic [CNT_W-1:0] r;
      r = (resp < CNT_W'(MIN_LATENCY_CYC)) ? CNT_W'(MIN_LATENCY_CYC) : resp;
      return r - CNT_W'(FILTER_CYC);
   endfunction : blank_len

   assign blank_end = blank_len(response_cyc_i);
   assign confirm = (state_reg == ST_WATCH) && over_threshold_i && (filt_reg == CNT_W'(FILTER_CYC - 1));

   // state sequencing
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_OFF;
      end
      else
      begin
         unique case (state_reg)
            ST_OFF:
            begin
               if (cmd_on_i)
                  state_reg <= ST_BLANK;
            end
            ST_BLANK:
            begin
               if (!cmd_on_i)
                  state_reg <= ST_OFF;
               else if (time_reg == blank_end - CNT_W'(1)) // [RULE_03] [RULE_06]
                  state_reg <= ST_WATCH;
            end
            ST_WATCH:
            begin
               if (confirm) // [RULE_04] [RULE_05] [RULE_07]
                  state_reg <= ST_SOFT_OFF;
               else if (!cmd_on_i)
                  state_reg <= ST_OFF;
            end
            ST_SOFT_OFF:
            begin
               if (ssd_reg == CNT_W'(SSD_CYC - 1)) // [RULE_11]
                  state_reg <= ST_BLOCKED;
            end
            ST_BLOCKED:
            begin
               // commands ignored until the hold expires [RULE_09]
               if (block_reg == CNT_W'(FAULT_HOLD_CYC - 1))
                  state_reg <= ST_OFF;
            end
            default:
               state_reg <= ST_OFF;
         endcase
      end
   end

   // time since turn-on, per-channel counter [RULE_12]
   always_ff @(posedge clock_i)
   begin
      if (rst_i || state_reg != ST_BLANK)
         time_reg <= '0;
      else
         time_reg <= time_reg + CNT_W'(1);
   end

   // filter restarts on any dip below threshold [RULE_04]
   always_ff @(posedge clock_i)
   begin
      if (rst_i || state_reg != ST_WATCH || !over_threshold_i)
         filt_reg <= '0;
      else
         filt_reg <= filt_reg + CNT_W'(1);
   end

   // soft shutdown duration counter
   always_ff @(posedge clock_i)
   begin
      if (rst_i || state_reg != ST_SOFT_OFF)
         ssd_reg <= '0;
      else
         ssd_reg <= ssd_reg + CNT_W'(1);
   end

   // fault hold counts from confirmation, covering soft shutdown too
   always_ff @(posedge clock_i)
   begin
      if (rst_i || confirm)
         block_reg <= '0;
      else if (state_reg == ST_SOFT_OFF || state_reg == ST_BLOCKED)
         block_reg <= block_reg + CNT_W'(1);
      else
         block_reg <= '0;
   end

   // gate stage drive
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         gate_turn_on_out_o <= 1'b0;
         gate_turn_off_out_o <= 1'b1;
         gate_level_o <= SSD_LEVEL_OFF;
         sense_clamp_o <= 1'b1;
      end
      else
      begin
         unique case (state_reg)
            ST_OFF:
            begin
               // timing capacitor discharged while off [RULE_01]
               gate_turn_on_out_o <= cmd_on_i; // [RULE_02]
               gate_turn_off_out_o <= !cmd_on_i;
               gate_level_o <= cmd_on_i ? SSD_LEVEL_FULL : SSD_LEVEL_OFF;
               sense_clamp_o <= !cmd_on_i; // [RULE_01]
            end
            ST_BLANK, ST_WATCH:
            begin
               gate_turn_on_out_o <= cmd_on_i && !confirm; // [RULE_02] [RULE_07]
               gate_turn_off_out_o <= !cmd_on_i && !confirm;
               gate_level_o <= (cmd_on_i && !confirm) ? SSD_LEVEL_FULL :
                  (confirm ? SSD_LEVEL_FULL - SSD_STEP_W'(1) : SSD_LEVEL_OFF);
               sense_clamp_o <= !cmd_on_i || confirm; // [RULE_01]
            end
            ST_SOFT_OFF:
            begin
               // both stages off; level ramps down from one below full, never rising [RULE_11]
               gate_turn_on_out_o <= 1'b0;
               gate_turn_off_out_o <= 1'b0;
               gate_level_o <= SSD_LEVEL_FULL - SSD_STEP_W'(1) -
                  SSD_STEP_W'((ssd_reg * CNT_W'(15)) / CNT_W'(SSD_CYC));
               sense_clamp_o <= 1'b1;
            end
            ST_BLOCKED:
            begin
               // negative drive keeps the switch off [RULE_07]
               gate_turn_on_out_o <= 1'b0;
               gate_turn_off_out_o <= 1'b1;
               gate_level_o <= SSD_LEVEL_OFF;
               sense_clamp_o <= 1'b1;
            end
            default:
            begin
               gate_turn_on_out_o <= 1'b0;
               gate_turn_off_out_o <= 1'b1;
               gate_level_o <= SSD_LEVEL_OFF;
               sense_clamp_o <= 1'b1;
            end
         endcase
      end
   end

   // fault report: low at once, released after the hold [RULE_08] [RULE_10]
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         fault_status_out_oe_o <= 1'b0;
         fault_pulse_o <= 1'b0;
      end
      else
      begin
         fault_pulse_o <= confirm;
         if (confirm)
            fault_status_out_oe_o <= 1'b1; // [RULE_08]
         else if (state_reg == ST_BLOCKED && block_reg == CNT_W'(FAULT_HOLD_CYC - 1))
            fault_status_out_oe_o <= 1'b0; // [RULE_10]
      end
   end
endmodule : desat_channel

// ### desat_pkg.sv
// constants and types for the desaturation detect and response block
package desat_pkg;
   localparam int CLK_MHZ = 250;
   localparam int CHANNELS = 2;
   // intervals in their own units
   localparam int BLANK_NS = 3000;
   localparam int FILTER_NS = 1000;
   localparam int MIN_LATENCY_NS = 4000;
   localparam int SSD_NS = 10000;
   localparam int FAULT_HOLD_MS = 10;
   // cycle counts: least times round up, none below one cycle
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int FILTER_CYC = (FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int MIN_LATENCY_CYC = (MIN_LATENCY_NS * CLK_MHZ + 999) / 1000;
   localparam int SSD_CYC = (SSD_NS * CLK_MHZ + 999) / 1000;
   localparam int FAULT_HOLD_CYC_DEF = FAULT_HOLD_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam int SSD_STEP_W = 4;
   localparam logic [SSD_STEP_W-1:0] SSD_LEVEL_FULL = 4'hF;
   localparam logic [SSD_STEP_W-1:0] SSD_LEVEL_OFF = 4'h0;
   // per-channel operating state
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_BLANK = 3'b001,
      ST_WATCH = 3'b010,
      ST_SOFT_OFF = 3'b011,
      ST_BLOCKED = 3'b100
   } chan_state_t;
endpackage : desat_pkg

// ### desat_short_circuit_detect.sv
// dual-channel desaturation short-circuit detect and response, secondary side
// Operation
// [RULE_01] off channel clamps sense node to negative rail
// [RULE_02] on command enables turn-on, disables turn-off stage
// [RULE_03] ignore sense comparator during 3 us blanking
// [RULE_04] fault needs 1 us continuous over-threshold
// [RULE_05] latency is filter plus longer of blanking, crossing
// [RULE_06] response floor 4 us; longer setting honoured
// [RULE_07] confirmed fault switches the channel off
// [RULE_08] fault status asserted at once on fault
// [RULE_09] commands ignored during blocking interval after fault
// [RULE_10] fault status held 10 ms then released
// [RULE_11] soft shutdown ramps gate down over 10 us
// [RULE_12] intervals are per-channel clock-derived cycle counters
module desat_short_circuit_detect
   import desat_pkg::*;
#(
   parameter int FAULT_HOLD_CYC = FAULT_HOLD_CYC_DEF
)
(
   input wire logic clock_i, // 250 MHz core clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic [CHANNELS-1:0] cmd_on_i, // per-channel switch command
   input wire logic [CHANNELS-1:0] collector_sense_i, // comparator: sense above threshold
   input wire logic [CNT_W-1:0] response_cyc_i, // configured response time, cycles
   output logic [CHANNELS-1:0] gate_turn_on_out_o, // turn-on stage enable
   output logic [CHANNELS-1:0] gate_turn_off_out_o, // turn-off stage enable
   output logic [2*SSD_STEP_W-1:0] gate_level_o, // per-channel gate level, ch0 low nibble
   output logic [CHANNELS-1:0] collector_sense_oe_o, // sense clamp to negative_rail
   output logic [CHANNELS-1:0] collector_sense_o, // clamp drive value, always low
   output logic [CHANNELS-1:0] fault_status_out_oe_o, // open-drain pull-down enable
   output logic [CHANNELS-1:0] fault_status_out_o, // open-drain value, always low
   output logic [CHANNELS-1:0] fault_pulse_o // one-cycle pulse per confirmed fault
);
   // drive value of open-drain and clamp pins is constant low
   always_ff @(posedge clock_i)
   begin
      collector_sense_o <= '0;
      fault_status_out_o <= '0;
   end

   // one instance per channel; channels share only the clock, reset and response setting
   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_chan
      desat_channel #(
         .FAULT_HOLD_CYC(FAULT_HOLD_CYC)
      ) u_chan (
         .clock_i(clock_i),
         .rst_i(rst_i),
         .cmd_on_i(cmd_on_i[c]),
         .over_threshold_i(collector_sense_i[c]),
         .response_cyc_i(response_cyc_i),
         .gate_turn_on_out_o(gate_turn_on_out_o[c]),
         .gate_turn_off_out_o(gate_turn_off_out_o[c]),
         .gate_level_o(gate_level_o[c*SSD_STEP_W +: SSD_STEP_W]),
         .sense_clamp_o(collector_sense_oe_o[c]),
         .fault_status_out_oe_o(fault_status_out_oe_o[c]),
         .fault_pulse_o(fault_pulse_o[c])
      );
   end
endmodule : desat_short_circuit_detect

// ### sense_net.sv
// partner model: collector sense network with a settable charge time
module sense_net
(
   input wire logic clock_i, // core clock
   input wire logic [1:0] gate_on_i, // turn-on stage enables
   input wire logic [1:0] clamp_i, // sense clamp enables
   input wire logic [1:0] short_i, // switch desaturated
   input wire logic [15:0] charge_cyc_i, // capacitor charge time, cycles
   output logic [1:0] sense_o // comparator, above threshold
);
   logic [15:0] chg_reg [2];
   // charge timer; the clamp empties the capacitor so each turn-on starts over
   always_ff @(posedge clock_i)
   begin
      for (int c = 0; c < 2; c++)
         chg_reg[c] <= (clamp_i[c] || !gate_on_i[c]) ? 16'h0 : chg_reg[c] + 16'h1;
   end
   // crossing only once charged, and only when the switch really desaturates
   always_comb
   begin
      for (int c = 0; c < 2; c++)
         sense_o[c] = short_i[c] && gate_on_i[c] && (chg_reg[c] >= charge_cyc_i);
   end
endmodule : sense_net

// ### desat_short_circuit_detect_chk.sv
// checker for the desaturation detect block, channel 0 watched
module desat_short_circuit_detect_chk
   import desat_pkg::*;
#(
   parameter int FAULT_HOLD_CYC = FAULT_HOLD_CYC_DEF
)
(
   input wire logic clock_i, // core clock
   input wire logic rst_i, // sync reset
   input wire logic [CHANNELS-1:0] cmd_on_i, // commands
   input wire logic [CHANNELS-1:0] collector_sense_i, // comparator
   input wire logic [CNT_W-1:0] response_cyc_i, // response time
   input wire logic [CHANNELS-1:0] gate_turn_on_out_o, // on stage
   input wire logic [CHANNELS-1:0] gate_turn_off_out_o, // off stage
   input wire logic [2*SSD_STEP_W-1:0] gate_level_o, // gate levels
   input wire logic [CHANNELS-1:0] collector_sense_oe_o, // clamp
   input wire logic [CHANNELS-1:0] fault_status_out_oe_o, // status
   input wire logic [CHANNELS-1:0] fault_pulse_o // fault pulse
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic [23:0] on_cnt, hi_cnt, soft_cnt, st_cnt;
   // run lengths; counters avoid long unrolled repetitions
   always_ff @(posedge clock_i)
      on_cnt <= (rst_i || !gate_turn_on_out_o[0]) ? 24'h0 : on_cnt + 24'h1;
   always_ff @(posedge clock_i)
      hi_cnt <= (rst_i || !collector_sense_i[0]) ? 24'h0 : hi_cnt + 24'h1;
   always_ff @(posedge clock_i)
      soft_cnt <= (rst_i || gate_turn_on_out_o[0] || gate_turn_off_out_o[0]) ? 24'h0 : soft_cnt + 24'h1;
   always_ff @(posedge clock_i)
      st_cnt <= (rst_i || !fault_status_out_oe_o[0]) ? 24'h0 : st_cnt + 24'h1;
   sequence soft_phase;
      !gate_turn_on_out_o[0] && !gate_turn_off_out_o[0];
   endsequence
   sequence soft_end;
      soft_phase ##1 gate_turn_off_out_o[0];
   endsequence
   a_clamp_when_off: assert property (gate_turn_off_out_o[0] |-> collector_sense_oe_o[0])
      else $error("sense not clamped while off");
   a_on_excludes_off: assert property (gate_turn_on_out_o[0] |-> !gate_turn_off_out_o[0] && gate_level_o[3:0] == 4'hF)
      else $error("on stage with off stage or partial level");
   a_blank_floor: assert property (fault_pulse_o[0] |-> on_cnt >= 24'h3E3)
      else $error("fault before blanking and filter elapsed");
   a_filter_run: assert property (fault_pulse_o[0] |-> hi_cnt >= 24'h0F9)
      else $error("fault without a full filter run");
   a_fault_cuts_gate: assert property (fault_pulse_o[0] |-> fault_status_out_oe_o[0] && !gate_turn_on_out_o[0])
      else $error("fault without status or gate cut");
   a_soft_start: assert property (fault_pulse_o[0] |-> soft_phase and gate_level_o[3:0] != 4'h0)
      else $error("shutdown not soft");
   a_soft_length: assert property (soft_end |-> soft_cnt >= 24'h9BA && soft_cnt <= 24'h9CE)
      else $error("soft shutdown length wrong");
   a_soft_falls: assert property (soft_phase ##1 soft_phase |-> gate_level_o[3:0] <= $past(gate_level_o[3:0]))
      else $error("gate level rose during soft shutdown");
   a_block_hold: assert property (fault_status_out_oe_o[0] |-> !gate_turn_on_out_o[0])
      else $error("gate on while blocked");
   a_status_hold: assert property ($fell(fault_status_out_oe_o[0]) |-> st_cnt >= FAULT_HOLD_CYC - 10 && st_cnt <= FAULT_HOLD_CYC + 10)
      else $error("status hold length wrong");
endmodule : desat_short_circuit_detect_chk

bind desat_short_circuit_detect desat_short_circuit_detect_chk #(.FAULT_HOLD_CYC(FAULT_HOLD_CYC)) chk_inst (.clock_i, .rst_i,
   .cmd_on_i, .collector_sense_i, .response_cyc_i, .gate_turn_on_out_o, .gate_turn_off_out_o, .gate_level_o,
   .collector_sense_oe_o, .fault_status_out_oe_o, .fault_pulse_o);

// ### desat_short_circuit_detect_tb.sv
// self-checking bench for the desaturation detect block
module desat_short_circuit_detect_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HOLD = 3000;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] cmd_on_i = 2'h0;
   logic [1:0] short_reg = 2'h0;
   logic [15:0] charge_reg = 16'h0;
   logic [23:0] response_cyc_i = 24'h0;
   logic [1:0] collector_sense_i, gate_turn_on_out_o, gate_turn_off_out_o, collector_sense_oe_o, fault_status_out_oe_o;
   logic [1:0] fault_pulse_o, collector_sense_o, fault_status_out_o;
   logic [7:0] gate_level_o;
   int errors = 0, num_checks = 0, cyc = 0;
   `define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
   always #2 clock_i = ~clock_i;
   desat_short_circuit_detect #(.FAULT_HOLD_CYC(HOLD)) desat_short_circuit_detect_inst (.clock_i, .rst_i, .cmd_on_i,
      .collector_sense_i, .response_cyc_i, .gate_turn_on_out_o, .gate_turn_off_out_o, .gate_level_o,
      .collector_sense_oe_o, .collector_sense_o, .fault_status_out_oe_o, .fault_status_out_o, .fault_pulse_o);
   sense_net sense_net_inst (.clock_i, .gate_on_i(gate_turn_on_out_o), .clamp_i(collector_sense_oe_o), .short_i(short_reg),
      .charge_cyc_i(charge_reg), .sense_o(collector_sense_i));
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   // hang guard: all runs together need about 24500 cycles
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errors++;
         $display("MISMATCH timeout exp 0 got 1");
         conclude();
      end
   end
   task step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : step
   // one fault from turn-on to resumed operation; gl dips the sense for one cycle
   task automatic fault_run(input int ch, input int resp, input int chg, input int gl, input int exp);
      int lat;
      lat = 0;
      response_cyc_i = resp[23:0];
      charge_reg = chg[15:0];
      short_reg[ch] = 1'b1;
      cmd_on_i[ch] = 1'b1;
      while (fault_pulse_o[ch] !== 1'b1 && lat < 5000)
      begin
         step(1);
         lat++;
         short_reg[ch] = (lat != gl);
      end
      `CHK("fault_latency", 1'b1, lat >= exp - 4 && lat <= exp + 4)
      `CHK("fault_status", 1'b1, fault_status_out_oe_o[ch])
      `CHK("gate_cut", 1'b0, gate_turn_on_out_o[ch])
      `CHK("other_quiet", 1'b0, fault_status_out_oe_o[1-ch])
      step(1);
      `CHK("pulse_single", 1'b0, fault_pulse_o[ch])
      `CHK("ssd_ramp", 1'b1, gate_level_o[4*ch +: 4] != 4'h0 && gate_level_o[4*ch +: 4] != 4'hF)
      step(2599);
      `CHK("blocked_on", 1'b0, gate_turn_on_out_o[ch])
      `CHK("ssd_level", 4'h0, gate_level_o[4*ch +: 4])
      lat = 0;
      while (fault_status_out_oe_o[ch] === 1'b1 && lat < HOLD)
      begin
         step(1);
         lat++;
      end
      `CHK("status_hold", 1'b1, lat + 2600 >= HOLD - 20 && lat + 2600 <= HOLD + 10)
      short_reg[ch] = 1'b0;
      cmd_on_i[ch] = 1'b0;
      step(3);
      `CHK("clamp_back", 1'b1, collector_sense_oe_o[ch])
      cmd_on_i[ch] = 1'b1;
      step(2);
      `CHK("resumed", 1'b1, gate_turn_on_out_o[ch])
      cmd_on_i[ch] = 1'b0;
      step(3);
   endtask : fault_run
   task t_normal;
      `CHK("reset_clamp", 2'h3, collector_sense_oe_o)
      cmd_on_i = 2'h1;
      step(1500);
      `CHK("on_stage", 2'h1, gate_turn_on_out_o)
      `CHK("off_stage", 2'h2, gate_turn_off_out_o)
      `CHK("level", 8'h0F, gate_level_o)
      `CHK("clamp_on", 2'h2, collector_sense_oe_o)
      `CHK("no_fault", 2'h0, fault_status_out_oe_o)
      `CHK("clamp_drive", 2'h0, collector_sense_o)
      `CHK("status_drive", 2'h0, fault_status_out_o)
      cmd_on_i = 2'h0;
      step(2);
      `CHK("clamp_off", 2'h3, collector_sense_oe_o)
      $display("test normal done");
   endtask : t_normal
   task t_floor;
      fault_run(0, 0, 0, 0, 1002);
      fault_run(1, 600, 0, 0, 1002);
      $display("test floor done");
   endtask : t_floor
   task t_long;
      fault_run(1, 1500, 0, 0, 1502);
      $display("test long done");
   endtask : t_long
   task t_charge;
      fault_run(0, 0, 1600, 0, 1852);
      $display("test charge done");
   endtask : t_charge
   task t_glitch;
      fault_run(0, 0, 1000, 1200, 1452);
      $display("test glitch done");
   endtask : t_glitch
   // reset in mid-fault must drop the report and bring back the off state
   task t_reset;
      response_cyc_i = 24'h0;
      charge_reg = 16'h0;
      short_reg = 2'h2;
      cmd_on_i = 2'h2;
      step(1100);
      `CHK("status_before_reset", 2'h2, fault_status_out_oe_o)
      rst_i = 1'b1;
      step(2);
      `CHK("reset_status", 2'h0, fault_status_out_oe_o)
      `CHK("reset_off", 2'h3, gate_turn_off_out_o)
      `CHK("reset_level", 8'h00, gate_level_o)
      rst_i = 1'b0;
      short_reg = 2'h0;
      cmd_on_i = 2'h0;
      step(2);
      `CHK("reset_clamp_back", 2'h3, collector_sense_oe_o)
      $display("test reset done");
   endtask : t_reset
   initial
   begin
      step(2);
      rst_i = 1'b0;
      step(1);
      t_normal();
      t_floor();
      t_long();
      t_charge();
      t_glitch();
      t_reset();
      conclude();
   end
endmodule : desat_short_circuit_detect_tb
